// ===== spg_pkg.sv
package spg_pkg;

   // ==========================================================
   // geometry
   localparam int SPG_SECTORS = 4;
   localparam int SPG_KEYS = 3;
   localparam int SPG_BLOCK_W = 7;
   localparam int SPG_SECTOR_LSB = 5;
   localparam int SPG_BYTE_ADDR_W = 9;
   localparam int SPG_I2C_ADDR_W = 11;

   // ==========================================================
   // guard byte layout
   localparam int SPG_SEAL_BIT = 0;
   localparam int SPG_RW_LSB = 1;
   localparam int SPG_KEYSEL_LSB = 3;
   localparam int SPG_CFG_W = 4;
   localparam logic [7:0] SPG_GUARD_RST = 8'h00;
   localparam logic [7:0] SPG_GUARD_MASK = 8'h1F;

   // read/write codes of a sealed sector
   localparam logic [1:0] SPG_RW_RFREE_WKEY = 2'h0;
   localparam logic [1:0] SPG_RW_FREE = 2'h1;
   localparam logic [1:0] SPG_RW_ALL_KEY = 2'h2;
   localparam logic [1:0] SPG_RW_NO_WRITE = 2'h3;

   // key selector: zero means no key
   localparam logic [1:0] SPG_KEYSEL_NONE = 2'h0;

   // ==========================================================
   // system area: guard word and key blocks
   localparam logic [1:0] SPG_OFS_GUARD = 2'h0;
   localparam logic [1:0] SPG_OFS_KEY1 = 2'h1;
   localparam logic [1:0] SPG_OFS_KEY2 = 2'h2;
   localparam logic [1:0] SPG_OFS_KEY3 = 2'h3;
   localparam logic [31:0] SPG_KEY_RST = 32'h00000000;
   localparam logic [SPG_I2C_ADDR_W-1:0] SPG_I2C_GUARD_BASE = 11'h000;

   // ==========================================================
   // commands and answers
   typedef enum logic [2:0] {
      SPG_OP_READ = 3'h0,
      SPG_OP_WRITE = 3'h1,
      SPG_OP_KEY_STORE = 3'h2,
      SPG_OP_SEAL = 3'h3,
      SPG_OP_KEY_OFFER = 3'h4
   } spg_op_t;

   typedef enum logic [1:0] {
      SPG_ST_OK = 2'h0,
      SPG_ST_DENIED = 2'h1,
      SPG_ST_ERR_SEALED = 2'h2,
      SPG_ST_ERR_ARG = 2'h3
   } spg_status_t;

endpackage

// ===== spg_access_check.sv
`timescale 1ns/1ps
`default_nettype none

module spg_access_check
   import spg_pkg::*;
(
   input wire logic [7:0] guard_in,
   input wire logic key_granted_in,
   output logic rd_ok_out,
   output logic wr_ok_out
);

   // ==========================================================
   // rights of one sector
   wire sealed = guard_in[SPG_SEAL_BIT];
   wire [1:0] rw_code = guard_in[SPG_RW_LSB +: 2];

   always_comb begin
      rd_ok_out = 1'b1;
      wr_ok_out = 1'b1;
      if (sealed) begin
         unique case (rw_code)
            SPG_RW_RFREE_WKEY: begin
               rd_ok_out = 1'b1;
               wr_ok_out = key_granted_in;
            end
            SPG_RW_FREE: begin
               rd_ok_out = 1'b1;
               wr_ok_out = 1'b1;
            end
            SPG_RW_ALL_KEY: begin
               rd_ok_out = key_granted_in;
               wr_ok_out = key_granted_in;
            end
            SPG_RW_NO_WRITE: begin
               rd_ok_out = key_granted_in;
               wr_ok_out = 1'b0;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ===== spg_sector_guard.sv
// Function
// - each of four sectors has its own guard byte, keyed by one of three keys
// - guard byte: seal bit 0, read/write code 2:1, key selector 4:3, 7:5 zero
// - allowed reads with option flag set return the sector's guard byte
// - guard bytes reset to zero: nothing sealed, no key linked
// - i2c reaches guard bytes with system area select high, bytes 0 to 3
// - unsealed sectors are freely readable and writable over rf
// - sealed: 00 read free, 01 all free, 10 all keyed, 11 no write
// - key selector 00 none, 01 to 11 link keys one to three
// - three 32-bit keys live at system addresses 1, 2 and 3
// - key store writes one key block, active once the write completes
// - key store accepted only after a valid offer of that key
// - all keys reset to zero and are active at once
// - seal writes bits 4:1 from the command and sets bit 0, effective next
// - sealed sectors refuse rf changes; sealing again answers an error
// - correct offer grants rights of that key until reset or next offer naming a key
// - wrong offer withdraws every granted right
// - i2c reads guard bytes always, writes only with the i2c key presented
// - i2c write to a guard byte sets that sector's rf access, effective next cycle
// - rf block n maps to i2c byte address 4n
`timescale 1ns/1ps
`default_nettype none

module spg_sector_guard
   import spg_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   // rf command port
   input wire logic rf_cmd_valid_in,
   input wire logic [2:0] rf_cmd_op_in,
   input wire logic [SPG_BLOCK_W-1:0] rf_block_in,
   input wire logic [1:0] rf_key_idx_in,
   input wire logic [SPG_CFG_W-1:0] rf_seal_cfg_in,
   input wire logic [31:0] rf_data_in,
   input wire logic rf_option_in,
   output logic rf_done_out,
   output logic [1:0] rf_status_out,
   output logic [7:0] rf_guard_out,
   output logic rf_guard_valid_out,
   output logic [SPG_BYTE_ADDR_W-1:0] rf_mem_addr_out,
   output logic [SPG_KEYS-1:0] key_granted_out,
   // i2c system area port
   input wire logic i2c_req_in,
   input wire logic i2c_we_in,
   input wire logic system_area_select_in,
   input wire logic [SPG_I2C_ADDR_W-1:0] i2c_addr_in,
   input wire logic [7:0] i2c_wdata_in,
   input wire logic i2c_key_ok_in,
   output logic i2c_ack_out,
   output logic i2c_nack_out,
   output logic [7:0] i2c_rdata_out
);

   // ==========================================================
   // storage
   logic [7:0] guard_q [SPG_SECTORS];
   logic [31:0] key_q [SPG_KEYS];
   logic [SPG_KEYS-1:0] granted_q;
   logic rf_done_q;
   logic [1:0] rf_status_q;
   logic [7:0] rf_guard_q;
   logic rf_guard_valid_q;
   logic [SPG_BYTE_ADDR_W-1:0] rf_mem_addr_q;
   logic i2c_ack_q;
   logic i2c_nack_q;
   logic [7:0] i2c_rdata_q;

   // ==========================================================
   // rf decode
   spg_op_t op;
   assign op = spg_op_t'(rf_cmd_op_in);

   wire [1:0] sector = rf_block_in[SPG_SECTOR_LSB +: 2];
   wire [7:0] guard_sel = guard_q[sector];
   wire sealed_sel = guard_sel[SPG_SEAL_BIT];
   wire [1:0] keysel = guard_sel[SPG_KEYSEL_LSB +: 2];
   wire key_idx_ok = (rf_key_idx_in != SPG_KEYSEL_NONE);
   wire [1:0] key_slot = rf_key_idx_in - 2'h1;
   wire [1:0] link_slot = keysel - 2'h1;
   // no linked key means no keyed rights at all
   wire link_granted = (keysel != SPG_KEYSEL_NONE) && granted_q[link_slot];
   wire key_match = key_idx_ok && (rf_data_in == key_q[key_slot]);

   wire rd_ok;
   wire wr_ok;

   spg_access_check u_check (
      .guard_in(guard_sel),
      .key_granted_in(link_granted),
      .rd_ok_out(rd_ok),
      .wr_ok_out(wr_ok)
   );

   wire is_read = rf_cmd_valid_in && (op == SPG_OP_READ);
   wire is_write = rf_cmd_valid_in && (op == SPG_OP_WRITE);
   wire is_store = rf_cmd_valid_in && (op == SPG_OP_KEY_STORE);
   wire is_seal = rf_cmd_valid_in && (op == SPG_OP_SEAL);
   wire is_offer = rf_cmd_valid_in && (op == SPG_OP_KEY_OFFER);

   // the key itself is writable only under its own granted flag
   wire store_ok = is_store && key_idx_ok && granted_q[key_slot];
   wire seal_ok = is_seal && !sealed_sel;
   wire offer_good = is_offer && key_match;
   wire offer_bad = is_offer && key_idx_ok && !key_match;

   spg_status_t rf_status_d;
   always_comb begin
      rf_status_d = SPG_ST_OK;
      unique case (op)
         SPG_OP_READ: rf_status_d = rd_ok ? SPG_ST_OK : SPG_ST_DENIED;
         SPG_OP_WRITE: rf_status_d = wr_ok ? SPG_ST_OK : SPG_ST_DENIED;
         SPG_OP_KEY_STORE: begin
            if (!key_idx_ok) begin
               rf_status_d = SPG_ST_ERR_ARG;
            end else begin
               rf_status_d = store_ok ? SPG_ST_OK : SPG_ST_DENIED;
            end
         end
         SPG_OP_SEAL: rf_status_d = sealed_sel ? SPG_ST_ERR_SEALED : SPG_ST_OK;
         SPG_OP_KEY_OFFER: begin
            if (!key_idx_ok) begin
               rf_status_d = SPG_ST_ERR_ARG;
            end else begin
               rf_status_d = key_match ? SPG_ST_OK : SPG_ST_DENIED;
            end
         end
         default: rf_status_d = SPG_ST_ERR_ARG;
      endcase
   end

   // guard byte rides along only on allowed reads with the option flag
   wire guard_ret = is_read && rf_option_in && rd_ok;

   // ==========================================================
   // i2c decode
   wire [SPG_I2C_ADDR_W-1:0] i2c_ofs = i2c_addr_in - SPG_I2C_GUARD_BASE;
   wire i2c_hit = i2c_req_in && system_area_select_in
                  && (i2c_addr_in >= SPG_I2C_GUARD_BASE)
                  && (i2c_ofs < SPG_I2C_ADDR_W'(SPG_SECTORS));
   wire [1:0] i2c_sector = i2c_ofs[1:0];
   wire i2c_wr_ok = i2c_hit && i2c_we_in && i2c_key_ok_in;
   wire i2c_rd = i2c_hit && !i2c_we_in;
   wire i2c_ack_d = i2c_rd || i2c_wr_ok;
   wire i2c_nack_d = i2c_req_in && !i2c_ack_d;
   wire [7:0] i2c_rdata_d = i2c_rd ? (guard_q[i2c_sector] & SPG_GUARD_MASK) : 8'h00;

   // ==========================================================
   // guard bytes, one per sector
   genvar gi;
   generate
      for (gi = 0; gi < SPG_SECTORS; gi++) begin : g_guard
         wire i2c_wr_here = i2c_wr_ok && (i2c_sector == 2'(gi));
         wire seal_here = seal_ok && (sector == 2'(gi));
         logic [7:0] guard_d;
         // i2c write wins a same-cycle clash: it is the later, keyed authority
         always_comb begin
            guard_d = guard_q[gi];
            if (i2c_wr_here) begin
               guard_d = i2c_wdata_in & SPG_GUARD_MASK;
            end else if (seal_here) begin
               guard_d = {3'h0, rf_seal_cfg_in, 1'b1};
            end
         end
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               guard_q[gi] <= SPG_GUARD_RST;
            end else begin
               guard_q[gi] <= guard_d;
            end
         end
      end
   endgenerate

   // ==========================================================
   // key blocks and granted flags
   genvar gk;
   generate
      for (gk = 0; gk < SPG_KEYS; gk++) begin : g_key
         wire store_here = store_ok && (key_slot == 2'(gk));
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               key_q[gk] <= SPG_KEY_RST;
            end else if (store_here) begin
               key_q[gk] <= rf_data_in;
            end
         end
      end
   endgenerate

   logic [SPG_KEYS-1:0] granted_d;
   always_comb begin
      granted_d = granted_q;
      if (offer_good) begin
         granted_d = SPG_KEYS'(3'h1 << key_slot);
      end else if (offer_bad) begin
         granted_d = '0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         granted_q <= '0;
      end else begin
         granted_q <= granted_d;
      end
   end

   // ==========================================================
   // answer registers
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rf_done_q <= 1'b0;
         rf_status_q <= SPG_ST_OK;
         rf_guard_q <= 8'h00;
         rf_guard_valid_q <= 1'b0;
         rf_mem_addr_q <= '0;
      end else begin
         rf_done_q <= rf_cmd_valid_in;
         rf_status_q <= rf_cmd_valid_in ? rf_status_d : SPG_ST_OK;
         rf_guard_q <= guard_ret ? (guard_sel & SPG_GUARD_MASK) : 8'h00;
         rf_guard_valid_q <= guard_ret;
         if (rf_cmd_valid_in) begin
            rf_mem_addr_q <= {rf_block_in, 2'h0};
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         i2c_ack_q <= 1'b0;
         i2c_nack_q <= 1'b0;
         i2c_rdata_q <= 8'h00;
      end else begin
         i2c_ack_q <= i2c_ack_d;
         i2c_nack_q <= i2c_nack_d;
         i2c_rdata_q <= i2c_rdata_d;
      end
   end

   assign rf_done_out = rf_done_q;
   assign rf_status_out = rf_status_q;
   assign rf_guard_out = rf_guard_q;
   assign rf_guard_valid_out = rf_guard_valid_q;
   assign rf_mem_addr_out = rf_mem_addr_q;
   assign key_granted_out = granted_q;
   assign i2c_ack_out = i2c_ack_q;
   assign i2c_nack_out = i2c_nack_q;
   assign i2c_rdata_out = i2c_rdata_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   wire seal_no_clash = seal_ok && !(i2c_wr_ok && i2c_sector == sector);

   AST_SEAL_SETS: assert property (
      seal_no_clash |=> guard_q[$past(sector)] == {3'h0, $past(rf_seal_cfg_in), 1'b1})
      else $error("seal did not load guard byte");

   AST_RESEAL_ERR: assert property (
      (is_seal && sealed_sel) |=> rf_done_q && rf_status_q == SPG_ST_ERR_SEALED)
      else $error("seal of sealed sector not refused");

   AST_OPEN_FREE: assert property (
      ((is_read || is_write) && !sealed_sel) |=> rf_status_q == SPG_ST_OK)
      else $error("unsealed sector access refused");

   AST_NO_WRITE_CODE: assert property (
      (is_write && sealed_sel && guard_sel[2:1] == SPG_RW_NO_WRITE)
      |=> rf_status_q == SPG_ST_DENIED)
      else $error("write allowed under no-write code");

   AST_STORE_GATED: assert property (
      (is_store && key_idx_ok && !granted_q[key_slot])
      |=> rf_status_q == SPG_ST_DENIED && key_q[$past(key_slot)] == $past(key_q[key_slot]))
      else $error("key stored without grant");

   AST_OFFER_GRANT: assert property (
      offer_good |=> granted_q == SPG_KEYS'(3'h1 << $past(key_slot)) ##1 1'b1)
      else $error("good offer not granted");

   AST_OFFER_WITHDRAW: assert property (
      offer_bad |=> granted_q == '0 && rf_status_q == SPG_ST_DENIED)
      else $error("bad offer kept rights");

   AST_I2C_KEYED: assert property (
      (i2c_hit && i2c_we_in && !i2c_key_ok_in && !(seal_ok && sector == i2c_sector))
      |=> i2c_nack_q && guard_q[$past(i2c_sector)] == $past(guard_q[i2c_sector]))
      else $error("guard write without i2c key");

   AST_I2C_SETS: assert property (
      i2c_wr_ok |=> guard_q[$past(i2c_sector)] == ($past(i2c_wdata_in) & SPG_GUARD_MASK))
      else $error("i2c guard write lost");

   AST_BYTE_MAP: assert property (
      rf_cmd_valid_in |=> rf_mem_addr_q == {$past(rf_block_in), 2'h0})
      else $error("block to byte map wrong");

   AST_GUARD_TOP: assert property (
      rf_guard_valid_q |-> rf_guard_q[7:5] == 3'h0 && i2c_rdata_q[7:5] == 3'h0)
      else $error("guard upper bits not zero");

   AST_OPTION_GUARD: assert property (
      (is_read && rf_option_in && rd_ok) |=> rf_guard_valid_q
      && rf_guard_q == ($past(guard_sel) & SPG_GUARD_MASK))
      else $error("guard byte not returned");

   AST_KEY_LANDS: assert property (
      store_ok |=> key_q[$past(key_slot)] == $past(rf_data_in))
      else $error("stored key not active");

   AST_FREE_CODE: assert property (
      ((is_read || is_write) && sealed_sel && guard_sel[2:1] == SPG_RW_FREE)
      |=> rf_status_q == SPG_ST_OK)
      else $error("free code access refused");

   AST_UNLINKED: assert property (
      (is_read && sealed_sel && keysel == SPG_KEYSEL_NONE
      && guard_sel[2:1] == SPG_RW_ALL_KEY) |=> rf_status_q == SPG_ST_DENIED)
      else $error("unlinked sector granted keyed read");

   AST_SEAL_KEEPS: assert property (
      (is_seal && sealed_sel && !(i2c_wr_ok && i2c_sector == sector))
      |=> guard_q[$past(sector)] == $past(guard_sel))
      else $error("sealed sector protection changed");

   AST_GRANT_HOLD: assert property (
      !is_offer |=> granted_q == $past(granted_q))
      else $error("granted flags changed without offer");

   AST_I2C_MISS: assert property (
      (i2c_req_in && !system_area_select_in) |=> i2c_nack_q && !i2c_ack_q)
      else $error("i2c access without select not refused");

   AST_I2C_READ: assert property (
      (i2c_hit && !i2c_we_in)
      |=> i2c_ack_q && i2c_rdata_q == ($past(guard_q[i2c_sector]) & SPG_GUARD_MASK))
      else $error("guard byte read refused");

endmodule

`default_nettype wire

// ===== spg_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// rf reader and i2c host: drive after the falling edge, one-cycle requests
module spg_host_model
   import spg_pkg::*;
(
   input wire logic clk_in,
   output logic rf_cmd_valid_out,
   output logic [2:0] rf_cmd_op_out,
   output logic [SPG_BLOCK_W-1:0] rf_block_out,
   output logic [1:0] rf_key_idx_out,
   output logic [SPG_CFG_W-1:0] rf_seal_cfg_out,
   output logic [31:0] rf_data_out,
   output logic rf_option_out,
   output logic i2c_req_out,
   output logic i2c_we_out,
   output logic system_area_select_out,
   output logic [SPG_I2C_ADDR_W-1:0] i2c_addr_out,
   output logic [7:0] i2c_wdata_out,
   output logic i2c_key_ok_out
);
   initial begin
      {rf_cmd_valid_out, rf_cmd_op_out, rf_block_out, rf_key_idx_out} = '0;
      {rf_seal_cfg_out, rf_data_out, rf_option_out} = '0;
      {i2c_req_out, i2c_we_out, system_area_select_out, i2c_addr_out} = '0;
      {i2c_wdata_out, i2c_key_ok_out} = '0;
   end

   // answer stands at the falling edge where the task returns
   task automatic rf(input logic [2:0] op, input logic [6:0] blk, input logic [1:0] idx,
         input logic [3:0] cfg, input logic [31:0] data, input logic opt);
      @(negedge clk_in);
      rf_cmd_valid_out = 1'b1;
      rf_cmd_op_out = op;
      rf_block_out = blk;
      rf_key_idx_out = idx;
      rf_seal_cfg_out = cfg;
      rf_data_out = data;
      rf_option_out = opt;
      @(negedge clk_in);
      rf_cmd_valid_out = 1'b0;
      // released data and block fields flip so stale values never look valid
      rf_data_out = ~data;
      rf_block_out = ~blk;
   endtask

   task automatic i2c(input logic we, input logic sel, input logic [10:0] addr,
         input logic [7:0] wdata, input logic key_ok);
      @(negedge clk_in);
      i2c_req_out = 1'b1;
      i2c_we_out = we;
      system_area_select_out = sel;
      i2c_key_ok_out = key_ok;
      i2c_addr_out = addr;
      i2c_wdata_out = wdata;
      @(negedge clk_in);
      i2c_req_out = 1'b0;
      i2c_wdata_out = ~wdata;
   endtask
endmodule

`default_nettype wire

// ===== spg_sector_guard_tb.sv
`timescale 1ns/1ps
`default_nettype none

module spg_sector_guard_tb
   import spg_pkg::*;
;
   logic clk_in, rst_n_in, rf_cmd_valid, rf_option, i2c_req, i2c_we, sel, i2c_key_ok;
   logic [2:0] rf_cmd_op;
   logic [SPG_BLOCK_W-1:0] rf_block;
   logic [1:0] rf_key_idx, rf_status;
   logic [SPG_CFG_W-1:0] rf_seal_cfg;
   logic [31:0] rf_data;
   logic [SPG_I2C_ADDR_W-1:0] i2c_addr;
   logic [7:0] i2c_wdata, rf_guard, i2c_rdata;
   logic rf_done, rf_guard_valid, i2c_ack, i2c_nack;
   logic [SPG_BYTE_ADDR_W-1:0] rf_mem_addr;
   logic [SPG_KEYS-1:0] key_granted;
   int n_errors = 0;
   int compares = 0;

   spg_sector_guard spg_sector_guard_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .rf_cmd_valid_in(rf_cmd_valid), .rf_cmd_op_in(rf_cmd_op), .rf_block_in(rf_block),
      .rf_key_idx_in(rf_key_idx), .rf_seal_cfg_in(rf_seal_cfg), .rf_data_in(rf_data),
      .rf_option_in(rf_option), .rf_done_out(rf_done), .rf_status_out(rf_status),
      .rf_guard_out(rf_guard), .rf_guard_valid_out(rf_guard_valid),
      .rf_mem_addr_out(rf_mem_addr), .key_granted_out(key_granted), .i2c_req_in(i2c_req),
      .i2c_we_in(i2c_we), .system_area_select_in(sel), .i2c_addr_in(i2c_addr),
      .i2c_wdata_in(i2c_wdata), .i2c_key_ok_in(i2c_key_ok), .i2c_ack_out(i2c_ack),
      .i2c_nack_out(i2c_nack), .i2c_rdata_out(i2c_rdata));

   spg_host_model spg_host_model_i (.clk_in(clk_in), .rf_cmd_valid_out(rf_cmd_valid),
      .rf_cmd_op_out(rf_cmd_op), .rf_block_out(rf_block), .rf_key_idx_out(rf_key_idx),
      .rf_seal_cfg_out(rf_seal_cfg), .rf_data_out(rf_data), .rf_option_out(rf_option),
      .i2c_req_out(i2c_req), .i2c_we_out(i2c_we), .system_area_select_out(sel),
      .i2c_addr_out(i2c_addr), .i2c_wdata_out(i2c_wdata), .i2c_key_ok_out(i2c_key_ok));

   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   // ==========================================================
   // shared helpers
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic rf(input logic [2:0] op, input logic [6:0] blk, input logic [1:0] idx,
         input logic [3:0] cfg, input logic [31:0] data, input logic opt);
      spg_host_model_i.rf(op, blk, idx, cfg, data, opt);
      chk("rf_done", rf_done, 1'b1);
   endtask

   task automatic i2(input logic we, input logic s, input logic [10:0] a,
         input logic [7:0] d, input logic ok, input logic ack_exp);
      spg_host_model_i.i2c(we, s, a, d, ok);
      chk("i2c_ack", i2c_ack, ack_exp);
      chk("i2c_nack", i2c_nack, !ack_exp);
   endtask

   task automatic acc(input logic [6:0] blk, input logic rd, input logic wr);
      rf(SPG_OP_READ, blk, 2'h0, 4'h0, 32'h0, 1'b1);
      chk("rd_status", rf_status, rd ? SPG_ST_OK : SPG_ST_DENIED);
      chk("guard_valid", rf_guard_valid, rd);
      rf(SPG_OP_WRITE, blk, 2'h0, 4'h0, 32'h0, 1'b0);
      chk("wr_status", rf_status, wr ? SPG_ST_OK : SPG_ST_DENIED);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset();
      chk("granted", key_granted, 3'h0);
      for (int s = 0; s < 4; s++) begin
         i2(1'b0, 1'b1, 11'(s), 8'h00, 1'b0, 1'b1);
         chk("guard_i2c", i2c_rdata, 8'h00);
      end
      i2(1'b0, 1'b0, 11'h000, 8'h00, 1'b0, 1'b0);
      i2(1'b0, 1'b1, 11'h004, 8'h00, 1'b0, 1'b0);
   endtask

   task automatic t_open();
      acc(7'h00, 1'b1, 1'b1);
      chk("mem_addr", rf_mem_addr, 9'h000);
      rf(SPG_OP_READ, 7'h20, 2'h0, 4'h0, 32'h0, 1'b0);
      chk("mem_addr", rf_mem_addr, 9'h080);
      rf(SPG_OP_WRITE, 7'h7F, 2'h0, 4'h0, 32'h0, 1'b0);
      chk("mem_addr", rf_mem_addr, 9'h1FC);
   endtask

   task automatic t_seal();
      for (int s = 0; s < 4; s++) begin
         rf(SPG_OP_SEAL, 7'(s * 32), 2'h0, {2'h1, 2'(s)}, 32'h0, 1'b0);
         chk("seal", rf_status, SPG_ST_OK);
         rf(SPG_OP_SEAL, 7'(s * 32 + 5), 2'h0, 4'h0, 32'h0, 1'b0);
         chk("reseal", rf_status, SPG_ST_ERR_SEALED);
         acc(7'(s * 32 + 1), s < 2, s == 1);
      end
      rf(SPG_OP_KEY_OFFER, 7'h00, 2'h1, 4'h0, SPG_KEY_RST, 1'b0);
      chk("granted", key_granted, 3'h1);
      for (int s = 0; s < 4; s++) begin
         rf(SPG_OP_READ, 7'(s * 32 + 7), 2'h0, 4'h0, 32'h0, 1'b1);
         chk("guard_rf", rf_guard, {3'h0, 2'h1, 2'(s), 1'b1});
         acc(7'(s * 32 + 2), 1'b1, s != 3);
      end
      rf(SPG_OP_KEY_OFFER, 7'h00, 2'h1, 4'h0, 32'h00000001, 1'b0);
      chk("granted", key_granted, 3'h0);
      acc(7'h40, 1'b0, 1'b0);
   endtask

   task automatic t_keys();
      rf(SPG_OP_KEY_OFFER, 7'h00, 2'h2, 4'h0, 32'h0, 1'b0);
      chk("granted", key_granted, 3'h2);
      acc(7'h40, 1'b0, 1'b0);
      rf(SPG_OP_KEY_STORE, 7'h00, 2'h2, 4'h0, 32'hA5A55A5A, 1'b0);
      chk("store", rf_status, SPG_ST_OK);
      rf(SPG_OP_KEY_OFFER, 7'h00, 2'h2, 4'h0, 32'h0, 1'b0);
      chk("granted", key_granted, 3'h0);
      rf(SPG_OP_KEY_STORE, 7'h00, 2'h3, 4'h0, 32'h00000001, 1'b0);
      chk("store", rf_status, SPG_ST_DENIED);
      rf(SPG_OP_KEY_OFFER, 7'h00, 2'h2, 4'h0, 32'hA5A55A5A, 1'b0);
      chk("granted", key_granted, 3'h2);
      rf(SPG_OP_KEY_OFFER, 7'h00, 2'h0, 4'h0, 32'h0, 1'b0);
      chk("bad_idx", rf_status, SPG_ST_ERR_ARG);
      chk("granted", key_granted, 3'h2);
      rf(3'h5, 7'h00, 2'h1, 4'h0, 32'h0, 1'b0);
      chk("bad_op", rf_status, SPG_ST_ERR_ARG);
   endtask

   task automatic t_i2c();
      i2(1'b1, 1'b1, 11'h002, 8'hFF, 1'b0, 1'b0);
      i2(1'b0, 1'b1, 11'h002, 8'h00, 1'b0, 1'b1);
      chk("guard_i2c", i2c_rdata, 8'h0D);
      i2(1'b1, 1'b1, 11'h002, 8'hFF, 1'b1, 1'b1);
      i2(1'b0, 1'b1, 11'h002, 8'h00, 1'b0, 1'b1);
      chk("guard_i2c", i2c_rdata, 8'h1F);
      acc(7'h41, 1'b0, 1'b0);
      // key 2 is granted here: linked it opens, unlinked it stays shut
      i2(1'b1, 1'b1, 11'h002, 8'h15, 1'b1, 1'b1);
      acc(7'h41, 1'b1, 1'b1);
      i2(1'b1, 1'b1, 11'h002, 8'h05, 1'b1, 1'b1);
      acc(7'h41, 1'b0, 1'b0);
      i2(1'b1, 1'b1, 11'h002, 8'h00, 1'b1, 1'b1);
      acc(7'h41, 1'b1, 1'b1);
   endtask

   // mid-run reset: rights, guard bytes and keys all fall back
   task automatic t_rearm();
      @(negedge clk_in);
      rst_n_in = 1'b0;
      @(negedge clk_in);
      chk("granted", key_granted, 3'h0);
      @(negedge clk_in);
      rst_n_in = 1'b1;
      i2(1'b0, 1'b1, 11'h000, 8'h00, 1'b0, 1'b1);
      chk("guard_i2c", i2c_rdata, 8'h00);
      rf(SPG_OP_KEY_OFFER, 7'h00, 2'h2, 4'h0, SPG_KEY_RST, 1'b0);
      chk("granted", key_granted, 3'h2);
   endtask

   // ==========================================================
   // sequence, watchdog and verdict
   task automatic close_out();
      if (n_errors == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      rst_n_in = 1'b0;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      rst_n_in = 1'b1;
      t_reset();
      t_open();
      t_seal();
      t_keys();
      t_i2c();
      t_rearm();
      close_out();
   end

   // about 70 two-cycle commands; more than ten times that margin
   initial begin
      #200000;
      n_errors++;
      close_out();
   end
endmodule

`default_nettype wire
